// *** tcp_dead.sv ***
// dead-band generator: delays the asserting edge of true and complementary outputs
`timescale 1ns/1ps
module tcp_dead #(
  parameter int DW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          pwm_in,
  input  wire logic [DW-1:0] dead_cycles,
  output logic               out_true,
  output logic               out_compl
);
  logic          prev;
  logic [DW-1:0] dcnt;
  logic          next_prev;
  logic [DW-1:0] next_dcnt;
  logic          next_true;
  logic          next_compl;

  // any level change restarts the gap, both outputs held off during it
  always_comb begin
    next_prev  = pwm_in;
    next_dcnt  = dcnt;
    next_true  = out_true;
    next_compl = out_compl;
    if (pwm_in != prev) begin
      next_dcnt  = dead_cycles;
      next_true  = 1'b0;
      next_compl = 1'b0;
    end else if (dcnt != '0) begin
      next_dcnt = dcnt - 1'b1;
    end else begin
      next_true  = pwm_in;
      next_compl = ~pwm_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev      <= 1'b0;
      dcnt      <= '0;
      out_true  <= 1'b0;
      out_compl <= 1'b0;
    end else begin
      prev      <= next_prev;
      dcnt      <= next_dcnt;
      out_true  <= next_true;
      out_compl <= next_compl;
    end
  end

  a_never_both_on: assert property (@(posedge aclk) disable iff (!aresetn)
    !(out_true && out_compl)) else $error("true and complement active together");
  a_dead_gap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(pwm_in) && dead_cycles != '0) |=> !out_true [*2])
    else $error("true output rose before dead band");
endmodule

// *** tcp_defs.svh ***
// register offsets, field positions and reset values of the timer/counter/pwm unit
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

`define TCP_OFS_CTRL    12'h000
`define TCP_OFS_STATUS  12'h004
`define TCP_OFS_COUNT   12'h008
`define TCP_OFS_PERIOD  12'h00c
`define TCP_OFS_CMP0    12'h010
`define TCP_OFS_CMP1    12'h014
`define TCP_OFS_CAPT    12'h018
`define TCP_OFS_DEAD    12'h01c

`define TCP_CTRL_RUN    0
`define TCP_CTRL_ONESHOT 1
`define TCP_CTRL_CAPEN  2
`define TCP_CTRL_KILLV  3
`define TCP_CTRL_START  4

`define TCP_PERIOD_RST  16'hffff
`define TCP_RESP_OKAY   2'b00
`define TCP_RESP_SLVERR 2'b10

`endif

// *** tcp_load.sv ***
// load on the pwm pins: counts cycles where a switch pair would conduct together
`timescale 1ns/1ps
module tcp_load (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        kill,
  input  wire logic [3:0]  pins,
  output logic [15:0]      overlap
);
  // both legs of one pair on shorts the supply; a forced kill state is excluded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overlap <= 16'h0000;
    end else if (!kill && ((pins[0] && pins[1]) || (pins[2] && pins[3]))) begin
      overlap <= overlap + 16'h0001;
    end
  end
endmodule

// *** tcp_pkg.sv ***
// types of the timer/counter/pwm unit
package tcp_pkg;
  typedef logic [15:0] tcp_cnt_t;
  typedef enum logic [1:0] {
    TCP_ST_IDLE,
    TCP_ST_RUN,
    TCP_ST_HALT
  } tcp_state_e;
endpackage

// *** tcp_top.sv ***
// timer/counter/pwm unit with axi4-lite register access
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tcp_defs.svh"

// Operation
// - 16-bit counter with programmable period
// - capture event stores current count
// - at period, halt or auto-reload
// - compare registers form pwm duty
// - true and complementary outputs with offset
// - shutdown forces outputs immediately
module tcp_top
  import tcp_pkg::*;
#(
  parameter int CW = 16,
  parameter int DW = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        capture_in,
  input  wire logic        kill_in,
  output logic             pwm0_true,
  output logic             pwm0_compl,
  output logic             pwm1_true,
  output logic             pwm1_compl
);
  import tcp_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [4:0]    ctrl;
  tcp_cnt_t      count;
  tcp_cnt_t      period;
  tcp_cnt_t      cmp [2];
  tcp_cnt_t      capt;
  logic [DW-1:0] dead;
  tcp_state_e    state;
  logic          cap_prev;
  logic          aw_hold;
  logic          w_hold;
  logic [11:0]   aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;

  logic [4:0]    next_ctrl;
  tcp_cnt_t      next_count;
  tcp_cnt_t      next_period;
  tcp_cnt_t      next_cmp [2];
  tcp_cnt_t      next_capt;
  logic [DW-1:0] next_dead;
  tcp_state_e    next_state;
  logic          next_aw_hold;
  logic          next_w_hold;
  logic [11:0]   next_aw_addr;
  logic [31:0]   next_w_data;
  logic [3:0]    next_w_strb;
  logic          next_bvalid;
  logic [1:0]    next_bresp;
  logic          next_rvalid;
  logic [31:0]   next_rdata;
  logic [1:0]    next_rresp;

  function automatic logic addr_known(input logic [11:0] a);
    case (a)
      `TCP_OFS_CTRL, `TCP_OFS_STATUS, `TCP_OFS_COUNT, `TCP_OFS_PERIOD,
      `TCP_OFS_CMP0, `TCP_OFS_CMP1, `TCP_OFS_CAPT, `TCP_OFS_DEAD: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic wr_go;
  logic [31:0] wr_val;
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    wr_val       = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = addr_known(aw_addr) ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = addr_known(s_axi_araddr) ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      case (s_axi_araddr)
        `TCP_OFS_CTRL:   next_rdata = {27'h0, ctrl};
        `TCP_OFS_STATUS: next_rdata = {29'h0, kill_in, state == TCP_ST_HALT,
                                       state == TCP_ST_RUN};
        `TCP_OFS_COUNT:  next_rdata = {16'h0, count};
        `TCP_OFS_PERIOD: next_rdata = {16'h0, period};
        `TCP_OFS_CMP0:   next_rdata = {16'h0, cmp[0]};
        `TCP_OFS_CMP1:   next_rdata = {16'h0, cmp[1]};
        `TCP_OFS_CAPT:   next_rdata = {16'h0, capt};
        `TCP_OFS_DEAD:   next_rdata = {{(32-DW){1'b0}}, dead};
        default:         next_rdata = 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // ----------------------------------------
    // register writes
    // ----------------------------------------
    next_ctrl   = ctrl;
    next_period = period;
    next_cmp    = cmp;
    next_dead   = dead;
    // start self-clears; a write of start in the same cycle lands after this and wins
    if (ctrl[`TCP_CTRL_START]) begin
      next_ctrl[`TCP_CTRL_START] = 1'b0;
    end
    if (wr_go) begin
      case (aw_addr)
        `TCP_OFS_CTRL:   wr_val = merge({27'h0, ctrl}, w_data, w_strb);
        `TCP_OFS_PERIOD: wr_val = merge({16'h0, period}, w_data, w_strb);
        `TCP_OFS_CMP0:   wr_val = merge({16'h0, cmp[0]}, w_data, w_strb);
        `TCP_OFS_CMP1:   wr_val = merge({16'h0, cmp[1]}, w_data, w_strb);
        `TCP_OFS_DEAD:   wr_val = merge({{(32-DW){1'b0}}, dead}, w_data, w_strb);
        default:         wr_val = 32'h0000_0000;
      endcase
      case (aw_addr)
        `TCP_OFS_CTRL:   next_ctrl   = wr_val[4:0];
        `TCP_OFS_PERIOD: next_period = wr_val[15:0];
        `TCP_OFS_CMP0:   next_cmp[0] = wr_val[15:0];
        `TCP_OFS_CMP1:   next_cmp[1] = wr_val[15:0];
        `TCP_OFS_DEAD:   next_dead   = wr_val[DW-1:0];
        default:         next_dead   = dead;
      endcase
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_count = count;
    next_capt  = capt;
    case (state)
      TCP_ST_IDLE, TCP_ST_HALT: begin
        if (ctrl[`TCP_CTRL_START] && ctrl[`TCP_CTRL_RUN]) begin
          next_state = TCP_ST_RUN;
          next_count = '0;
        end
      end
      TCP_ST_RUN: begin
        if (!ctrl[`TCP_CTRL_RUN]) begin
          next_state = TCP_ST_IDLE;
        end else if (count == period) begin
          if (ctrl[`TCP_CTRL_ONESHOT]) begin
            next_state = TCP_ST_HALT;
          end else begin
            next_count = '0;
          end
        end else begin
          next_count = count + 1'b1;
        end
      end
      default: next_state = TCP_ST_IDLE;
    endcase
    // rising edge on the capture pin samples the live count
    if (ctrl[`TCP_CTRL_CAPEN] && capture_in && !cap_prev) begin
      next_capt = count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl          <= 5'h00;
      count         <= '0;
      period        <= `TCP_PERIOD_RST;
      cmp[0]        <= '0;
      cmp[1]        <= '0;
      capt          <= '0;
      dead          <= '0;
      state         <= TCP_ST_IDLE;
      cap_prev      <= 1'b0;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      ctrl          <= next_ctrl;
      count         <= next_count;
      period        <= next_period;
      cmp           <= next_cmp;
      capt          <= next_capt;
      dead          <= next_dead;
      state         <= next_state;
      cap_prev      <= capture_in;
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ----------------------------------------
  // pwm channels
  // ----------------------------------------
  logic [1:0] raw_true;
  logic [1:0] raw_compl;
  logic [1:0] duty;
  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign duty[g] = (state == TCP_ST_RUN) && (count < cmp[g]);
    tcp_dead #(.DW(DW)) u_dead (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .pwm_in      (duty[g]),
      .dead_cycles (dead),
      .out_true    (raw_true[g]),
      .out_compl   (raw_compl[g])
    );
  end

  // kill bypasses the registers so all four outputs take the KILLV level the same cycle
  logic kv;
  assign kv         = ctrl[`TCP_CTRL_KILLV];
  assign pwm0_true  = kill_in ? kv : raw_true[0];
  assign pwm0_compl = kill_in ? kv : raw_compl[0];
  assign pwm1_true  = kill_in ? kv : raw_true[1];
  assign pwm1_compl = kill_in ? kv : raw_compl[1];

  a_kill_forces: assert property (@(posedge aclk) disable iff (!aresetn)
    kill_in |-> (pwm0_true == kv && pwm0_compl == kv && pwm1_true == kv && pwm1_compl == kv))
    else $error("kill not forcing");
  a_reload_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == TCP_ST_RUN && ctrl[`TCP_CTRL_RUN] && !ctrl[`TCP_CTRL_ONESHOT] && count == period)
    |=> count == 16'h0000) else $error("no reload at period");
  a_oneshot_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == TCP_ST_RUN && ctrl[`TCP_CTRL_RUN] && ctrl[`TCP_CTRL_ONESHOT] && count == period)
    |=> (state == TCP_ST_HALT && count == $past(count))) else $error("no halt at period");
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == TCP_ST_RUN && ctrl[`TCP_CTRL_RUN] && count != period)
    |=> count == $past(count) + 16'h0001) else $error("counter did not step");
  a_capture_val: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[`TCP_CTRL_CAPEN] && capture_in && !cap_prev) |=> capt == $past(count))
    else $error("capture value wrong");
  a_duty_cmp: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwm0_true && !kill_in) |-> $past(duty[0])) else $error("true output without duty");
endmodule

// *** test_timer_counter_pwm.sv ***
// self-checking bench of the timer/counter/pwm unit
`timescale 1ns/1ps
`include "tcp_defs.svh"
module test_timer_counter_pwm;
  import tcp_pkg::*;
  localparam int P = 40;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, capture_in, kill_in;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb, pins;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] overlap;
  int          fails = 0, checks_done = 0, cyc = 0, c0, c1, dd;
  int          h[4];

  tcp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_in(capture_in), .kill_in(kill_in),
    .pwm0_true(pins[0]), .pwm0_compl(pins[1]), .pwm1_true(pins[2]),
    .pwm1_compl(pins[3]));
  tcp_load load (.aclk(aclk), .aresetn(aresetn), .kill(kill_in), .pins(pins),
    .overlap(overlap));

  // ----------------------------------------
  // checking and reporting
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t resp %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_p(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t pins %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // axi4-lite master
  // ----------------------------------------
  // handshakes are sampled at the rising edge, before that edge's updates land;
  // response ready lines stay high between calls so no call drives them twice
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      done = bvalid && bready;
      r = bresp;
    end
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      done = rvalid && rready;
      d = rdata;
      r = rresp;
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, capture_in, kill_in} = 8'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    void'($urandom(16));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`TCP_OFS_PERIOD, rv, rs);
    chk_d(rv, 32'h0000ffff);
    chk_r(rs, `TCP_RESP_OKAY);
    axi_rd(12'h0f0, rv, rs);
    chk_r(rs, `TCP_RESP_SLVERR);
    axi_wr(12'h0f0, 32'h1, rs);
    chk_r(rs, `TCP_RESP_SLVERR);
    $display("test reset done");
    // one-shot: counter parks on the period, so the capture value is exact
    axi_wr(`TCP_OFS_PERIOD, P, rs);
    chk_r(rs, `TCP_RESP_OKAY);
    axi_wr(`TCP_OFS_CTRL, 32'h17, rs);
    repeat (P + 10) @(posedge aclk);
    axi_rd(`TCP_OFS_COUNT, rv, rs);
    chk_d(rv, P);
    axi_rd(`TCP_OFS_STATUS, rv, rs);
    chk_d(rv, 32'h2);
    capture_in <= 1'b1;
    repeat (2) @(posedge aclk);
    capture_in <= 1'b0;
    axi_rd(`TCP_OFS_CAPT, rv, rs);
    chk_d(rv, P);
    $display("test oneshot done");
    // auto-reload pwm with random duty and dead band, the first with none
    for (int i = 0; i < 3; i++) begin
      c0 = $urandom_range(30, 8);
      c1 = $urandom_range(30, 8);
      dd = (i == 0) ? 0 : $urandom_range(5, 1);
      axi_wr(`TCP_OFS_CTRL, 32'h0, rs);
      axi_wr(`TCP_OFS_CMP0, c0, rs);
      axi_wr(`TCP_OFS_CMP1, c1, rs);
      axi_wr(`TCP_OFS_DEAD, dd, rs);
      axi_wr(`TCP_OFS_CTRL, 32'h11, rs);
      repeat (3 * (P + 1)) @(posedge aclk);
      h = '{0, 0, 0, 0};
      repeat (4 * (P + 1)) begin
        @(negedge aclk);
        for (int j = 0; j < 4; j++) h[j] += pins[j];
      end
      chk_d(h[0], 4 * (c0 - dd - 1));
      chk_d(h[1], 4 * (P - c0 - dd));
      chk_d(h[2], 4 * (c1 - dd - 1));
      chk_d(h[3], 4 * (P - c1 - dd));
    end
    $display("test pwm done");
    // kill must act in the same cycle, to either forced level
    for (int k = 0; k < 2; k++) begin
      axi_wr(`TCP_OFS_CTRL, 32'h11 | (k << 3), rs);
      repeat (P / 2) @(posedge aclk);
      kill_in <= 1'b1;
      @(negedge aclk);
      chk_p(pins, {4{k[0]}});
      @(posedge aclk);
      axi_rd(`TCP_OFS_STATUS, rv, rs);
      chk_d(rv, 32'h5);
      kill_in <= 1'b0;
    end
    chk_d(overlap, 32'h0);
    $display("test kill done");
    final_report();
  end
endmodule
